// ---- char_fifo.sv ----
// Purpose : Synchronous FIFO with valid/ready on both sides.
// Assumes : DEPTH is a power of two.
// Notes   : Input ready is registered; all state freezes with i_ce low.

`timescale 1ns/1ns
`default_nettype none

module char_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   input  wire logic             i_mclk,
   input  wire logic             i_resetn,
   input  wire logic             i_ce,
   input  wire logic [WIDTH-1:0] i_in_data,
   input  wire logic             i_in_valid,
   output var  logic             o_in_ready,
   output var  logic [WIDTH-1:0] o_out_data,
   output var  logic             o_out_valid,
   input  wire logic             i_out_ready
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
      logic          rdy;
   } fifo_state_t;

   fifo_state_t      r;
   fifo_state_t      n;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             push;
   logic             pop;

   assign push        = i_in_valid && r.rdy && i_ce;
   assign pop         = i_out_ready && (r.cnt != '0) && i_ce;
   assign o_in_ready  = r.rdy;
   assign o_out_valid = (r.cnt != '0);
   assign o_out_data  = mem[r.rp];

   always_comb begin
      n = r;
      if (push) begin
         n.wp = r.wp + 1'b1;
      end
      if (pop) begin
         n.rp = r.rp + 1'b1;
      end
      if (push && !pop) begin
         n.cnt = r.cnt + 1'b1;
      end else if (pop && !push) begin
         n.cnt = r.cnt - 1'b1;
      end
      // Ready registered from next count
      n.rdy = (n.cnt != (AW+1)'(DEPTH));
   end

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         r <= '{wp: '0, rp: '0, cnt: '0, rdy: 1'b1};
      end else if (i_ce) begin
         r <= n;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (push) begin
         mem[r.wp] <= i_in_data;
      end
   end

endmodule

`default_nettype wire

// ---- dm_model.sv ----
// Purpose : Display memory seen from the translation unit.
// Assumes : Writes are one-cycle strobes on i_mclk.
// Notes   : Bench reads mem to check where codes landed.
`timescale 1ns/1ns
`default_nettype none
module dm_model
   import tct_pkg::*;
(
   input wire logic              i_mclk,
   input wire logic              i_we,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [7:0]        i_data
);
   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [7:0] mem [0:SCR_ROWS*SCR_COLS-1];
   always_ff @(posedge i_mclk) begin
      if (i_we) begin
         mem[i_addr] <= i_data;
      end
   end
endmodule
`default_nettype wire

// ---- tct_checker.sv ----
// Purpose : Port-level checks on the translation unit.
// Assumes : One clock domain, bound to the top module.
// Notes   : Key checks apply only to keys the unit accepts.
`timescale 1ns/1ns
`default_nettype none
module tct_checker
   import tct_pkg::*;
(
   input wire logic             i_mclk,
   input wire logic             i_resetn,
   input wire logic             i_ce,
   input wire logic             i_wr_start,
   input wire logic             i_typewriter,
   input wire logic             i_key_valid,
   input wire logic [6:0]       i_key_pos,
   input wire logic             i_tx_valid,
   input wire logic [7:0]       i_tx_byte,
   input wire logic             i_tx_kana,
   input wire logic             o_tx_valid,
   input wire logic [7:0]       o_tx_byte,
   input wire logic             i_frame_start,
   input wire logic             o_odd_field,
   input wire logic             o_dm_we,
   input wire logic [7:0]       o_dm_data,
   input wire logic [ROW_W-1:0] o_top_row,
   input wire logic [ROW_W-1:0] o_cursor_row,
   input wire logic [COL_W-1:0] o_cursor_col,
   input wire logic             o_idle,
   input wire logic             o_kbd_ctrl_valid,
   input wire logic [7:0]       o_kbd_ctrl,
   input wire logic             o_kana_entry
);
   // ----------------------------------------------------------------
   // Port relations
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_resetn);
   logic key_go;
   assign key_go = i_key_valid && o_idle && !i_wr_start && i_ce;
   sequence s_tw_go;
      i_wr_start && o_idle && i_typewriter && i_ce;
   endsequence
   sequence s_blanks;
      (o_dm_we && o_dm_data == C_SPACE)[*8];
   endsequence
   chk_tx_timing: assert property (i_tx_valid && i_ce |=> o_tx_valid)
      else $error("tx answer missing");
   chk_tx_plain: assert property (i_tx_valid && i_ce && !i_tx_kana
      |=> o_tx_byte == $past(i_tx_byte)) else $error("tx byte changed");
   chk_tx_kana: assert property (i_tx_valid && i_ce && i_tx_kana
      && i_tx_byte[7:4] == 4'h6 |=> o_tx_byte == {4'hC,
      $past(i_tx_byte[3:0])}) else $error("tx kana map wrong");
   chk_field_flip: assert property (i_frame_start && i_ce
      |=> o_odd_field != $past(o_odd_field)) else $error("field stuck");
   chk_key_ctrl: assert property (key_go
      && i_key_pos[6:4] == KEY_ROW_CTRL |=> o_kbd_ctrl_valid
      && o_kbd_ctrl == {4'h0, $past(i_key_pos[3:0])})
      else $error("key control code wrong");
   chk_key_latin: assert property (key_go && !o_kana_entry
      && i_key_pos[6:4] < KEY_ROW_CTRL |=> o_dm_we && o_dm_data
      == (({1'b0, $past(i_key_pos)} + KEY_LAT_OFS) | 8'h80))
      else $error("latin key store wrong");
   chk_kana_key: assert property (key_go && i_key_pos == KEY_KANA
      |=> o_kana_entry) else $error("kana mode not entered");
   chk_latin_key: assert property (key_go && i_key_pos == KEY_LATIN
      |=> !o_kana_entry) else $error("latin mode not entered");
   chk_tw_rollup: assert property (s_tw_go |=> o_top_row ==
      (($past(o_top_row) == 5'd23) ? 5'd0 : $past(o_top_row) + 5'd1))
      else $error("roll-up missing");
   chk_tw_clear: assert property (s_tw_go |=> (o_cursor_row == 5'd23
      && o_cursor_col == 7'd0 && !o_idle) ##1 s_blanks)
      else $error("bottom line not cleared");
endmodule
bind terminal_char_translation tct_checker tct_checker_inst (.*);
`default_nettype wire

// ---- tct_pkg.sv ----
// Purpose : Constants and types of the translation unit and FIFO.
// Assumes : One clock domain, display of SCR_ROWS x SCR_COLS cells.
// Notes   : Display addresses are row * SCR_COLS + column.

`default_nettype none

package tct_pkg;

   // ----------------------------------------------------------------
   // Display geometry
   // ----------------------------------------------------------------
   localparam int SCR_COLS = 80;
   localparam int SCR_ROWS = 24;
   localparam int COL_W    = 7;
   localparam int ROW_W    = 5;
   localparam int ADDR_W   = 11;
   localparam int FG_BIT   = 7;

   // ----------------------------------------------------------------
   // Host stream codes
   // ----------------------------------------------------------------
   localparam logic [7:0] C_CTRL_MAX  = 8'h0F;
   localparam logic [7:0] C_CR        = 8'h0D;
   localparam logic [7:0] C_XMARK_IN  = 8'h0C;
   localparam logic [7:0] C_RJF_IN    = 8'h0B;
   localparam logic [7:0] C_KANA_IN   = 8'h0F;
   localparam logic [7:0] C_STOP1     = 8'h04;
   localparam logic [7:0] C_STOP2     = 8'h09;
   localparam logic [7:0] C_LOW_MAX   = 8'h03;

   // ----------------------------------------------------------------
   // Display memory codes
   // ----------------------------------------------------------------
   localparam logic [7:0] C_SPACE     = 8'h20;
   localparam logic [7:0] C_SUPP_NULL = 8'h80;
   localparam logic [7:0] C_XMARK     = 8'h81;
   localparam logic [7:0] C_RJF       = 8'h82;
   localparam logic [7:0] C_XSTOP     = 8'h83;

   // ----------------------------------------------------------------
   // Keyboard position codes: row in [6:4], column in [3:0]
   // ----------------------------------------------------------------
   localparam logic [2:0] KEY_ROW_CTRL = 3'h6;
   localparam logic [2:0] KEY_ROW_SPEC = 3'h7;
   localparam logic [6:0] KEY_KANA     = 7'h70;
   localparam logic [6:0] KEY_LATIN    = 7'h71;
   localparam logic [7:0] KEY_LAT_OFS  = 8'h20;
   localparam logic [7:0] KEY_KANA_OFS = 8'h80;

   // ----------------------------------------------------------------
   // Buffering
   // ----------------------------------------------------------------
   localparam int HOST_W     = 9;
   localparam int FIFO_DEPTH = 32;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CLEAR,
      ST_DATA,
      ST_MARK
   } wr_state_t;

endpackage

`default_nettype wire

// ---- terminal_char_translation.sv ----
// Purpose : Host and key codes to display memory codes,
//           with typewriter roll-up.
// Assumes : Host bytes and key codes come from logic on i_mclk.
// Notes   : Roll-up moves the top-row pointer; no memory copy.
//
// Overview of operation
// - Key position codes become ASCII before storage; control-row keys give 0 and the column.
// - Display memory gets 7-bit codes plus foreground bit, or codes 80 to 83.
// - Host messages carry a block check verified at message end.
// - Video slices interlace over two sweeps; field toggles per frame.
// - Typewriter write start rolls up, homes bottom line, background.
// - Carriage return in typewriter rolls up, blanks bottom, homes.
// - Typewriter write drops data that runs past the display end.
// - Completed untruncated typewriter write places a transmit mark at data end.
// - Kana introducer 0F is stored as the transmit-stop code 83.
// - After a Kana field, keyboard enters Kana until Latin key.
// - Keyboard starts Latin; Kana key switches to Katakana codes.
// - Stored byte: 7-bit code, top bit flags foreground.
// - Kana A-D high nibble stored as 0,1,6,7; reversed on transmit.
// - Transmit-mark byte 0C is stored as 81.
// - Right-justified-field byte 0B is stored as 82.
// - Sequence 04 09 is stored as one transmit-stop code 83.
// - Bytes up to 0F are commands, higher bytes are data.
// - Data loses top bit; 00 to 03 become space.

`timescale 1ns/1ns
`default_nettype none

module terminal_char_translation
   import tct_pkg::*;
(
   input  wire logic              i_mclk,
   input  wire logic              i_resetn,
   input  wire logic              i_ce,
   input  wire logic [7:0]        i_host_data,
   input  wire logic              i_host_last,
   input  wire logic              i_host_valid,
   output var  logic              o_host_ready,
   input  wire logic              i_wr_start,
   input  wire logic              i_typewriter,
   input  wire logic              i_fg_mode,
   input  wire logic              i_key_valid,
   input  wire logic [6:0]        i_key_pos,
   input  wire logic              i_tx_valid,
   input  wire logic [7:0]        i_tx_byte,
   input  wire logic              i_tx_kana,
   output var  logic              o_tx_valid,
   output var  logic [7:0]        o_tx_byte,
   input  wire logic              i_frame_start,
   output var  logic              o_odd_field,
   output var  logic              o_dm_we,
   output var  logic [ADDR_W-1:0] o_dm_addr,
   output var  logic [7:0]        o_dm_data,
   output var  logic [ROW_W-1:0]  o_top_row,
   output var  logic [ROW_W-1:0]  o_cursor_row,
   output var  logic [COL_W-1:0]  o_cursor_col,
   output var  logic              o_idle,
   output var  logic              o_kbd_ctrl_valid,
   output var  logic [7:0]        o_kbd_ctrl,
   output var  logic              o_write_done,
   output var  logic              o_bcc_ok,
   output var  logic              o_kana_entry
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      wr_state_t         st;
      logic [ROW_W-1:0]  top;
      logic [ROW_W-1:0]  row;
      logic [COL_W-1:0]  col;
      logic [COL_W-1:0]  clr;
      logic              fg;
      logic              tw;
      logic              trunc;
      logic              esc;
      logic              kana_seen;
      logic              kbd_kana;
      logic [7:0]        bcc;
      logic              bcc_ok;
      logic              dm_we;
      logic [ADDR_W-1:0] dm_addr;
      logic [7:0]        dm_data;
      logic              idle;
      logic              kc_v;
      logic [7:0]        kc;
      logic              done;
      logic              tx_v;
      logic [7:0]        tx_byte;
      logic              odd;
   } tct_state_t;

   tct_state_t       r;
   tct_state_t       n;
   logic [HOST_W-1:0] f_data;
   logic             f_valid;
   logic             f_pop;
   logic             do_st;
   logic [7:0]       st_val;
   logic [7:0]       b;

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   function automatic logic [ROW_W-1:0] inc_row(input logic [ROW_W-1:0] x);
      return (x == ROW_W'(SCR_ROWS - 1)) ? '0 : x + 1'b1;
   endfunction

   function automatic logic [ADDR_W-1:0] phys(
      input logic [ROW_W-1:0] row,
      input logic [COL_W-1:0] col,
      input logic [ROW_W-1:0] top
   );
      logic [ROW_W:0] s;
      s = {1'b0, row} + {1'b0, top};
      if (s >= (ROW_W+1)'(SCR_ROWS)) begin
         s = s - (ROW_W+1)'(SCR_ROWS);
      end
      return ADDR_W'(s) * ADDR_W'(SCR_COLS) + ADDR_W'(col);
   endfunction

   // Data byte to display code
   function automatic logic [7:0] xlate(input logic [7:0] d,
                                        input logic       fg);
      logic [7:0] v;
      v = {1'b0, d[6:0]};
      if (d[7:5] == 3'b101 || d[7:5] == 3'b110) begin
         v = {1'b0, d[6], d[6], d[4], d[3:0]};
      end else if (v <= C_LOW_MAX) begin
         v = C_SPACE;
      end
      v[FG_BIT] = fg;
      return v;
   endfunction

   function automatic logic [7:0] unxlate(input logic [7:0] s);
      logic [7:0] v;
      v = s;
      if (s[6] == s[5]) begin
         v = {1'b1, s[5], ~s[5], s[4], s[3:0]};
      end
      return v;
   endfunction

   function automatic logic [7:0] key_ascii(input logic [6:0] pos,
                                            input logic       kana);
      return {1'b0, pos} + (kana ? KEY_KANA_OFS : KEY_LAT_OFS);
   endfunction

   // ----------------------------------------------------------------
   // Host data buffer
   // ----------------------------------------------------------------
   char_fifo #(
      .WIDTH (HOST_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .i_mclk      (i_mclk),
      .i_resetn    (i_resetn),
      .i_ce        (i_ce),
      .i_in_data   ({i_host_last, i_host_data}),
      .i_in_valid  (i_host_valid),
      .o_in_ready  (o_host_ready),
      .o_out_data  (f_data),
      .o_out_valid (f_valid),
      .i_out_ready (f_pop)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      n      = r;
      f_pop  = 1'b0;
      do_st  = 1'b0;
      st_val = C_SPACE;
      b      = f_data[7:0];
      n.dm_we = 1'b0;
      n.kc_v  = 1'b0;
      n.done  = 1'b0;
      n.tx_v  = 1'b0;
      if (i_frame_start) begin
         n.odd = ~r.odd;
      end
      if (i_tx_valid) begin
         n.tx_v    = 1'b1;
         n.tx_byte = i_tx_kana ? unxlate(i_tx_byte) : i_tx_byte;
      end
      unique case (r.st)
         ST_IDLE: begin
            if (i_wr_start) begin
               n.tw        = i_typewriter;
               n.trunc     = 1'b0;
               n.esc       = 1'b0;
               n.kana_seen = 1'b0;
               n.bcc       = '0;
               if (i_typewriter) begin
                  n.top = inc_row(r.top);
                  n.row = ROW_W'(SCR_ROWS - 1);
                  n.col = '0;
                  n.fg  = 1'b0;
                  n.clr = '0;
                  n.st  = ST_CLEAR;
               end else begin
                  n.fg = i_fg_mode;
                  n.st = ST_DATA;
               end
            end else if (i_key_valid) begin
               if (i_key_pos == KEY_KANA) begin
                  n.kbd_kana = 1'b1;
               end else if (i_key_pos == KEY_LATIN) begin
                  n.kbd_kana = 1'b0;
               end else if (i_key_pos[6:4] == KEY_ROW_CTRL) begin
                  n.kc_v = 1'b1;
                  n.kc   = {4'h0, i_key_pos[3:0]};
               end else if (i_key_pos[6:4] != KEY_ROW_SPEC) begin
                  do_st  = 1'b1;
                  st_val = xlate(key_ascii(i_key_pos, r.kbd_kana), 1'b1);
               end
            end
         end
         ST_CLEAR: begin
            n.dm_we   = 1'b1;
            n.dm_addr = phys(ROW_W'(SCR_ROWS - 1), r.clr, r.top);
            n.dm_data = C_SPACE;
            if (r.clr == COL_W'(SCR_COLS - 1)) begin
               n.st = ST_DATA;
            end else begin
               n.clr = r.clr + 1'b1;
            end
         end
         ST_DATA: begin
            if (f_valid) begin
               f_pop = 1'b1;
               n.bcc = r.bcc ^ b;
               if (f_data[8]) begin
                  n.bcc_ok = ((r.bcc ^ b) == 8'h00);
                  if (r.kana_seen) begin
                     n.kbd_kana = 1'b1;
                  end
                  if (r.tw) begin
                     n.st = ST_MARK;
                  end else begin
                     n.st   = ST_IDLE;
                     n.done = 1'b1;
                  end
               end else if (r.trunc) begin
                  n.esc = 1'b0;
               end else if (r.esc) begin
                  n.esc = 1'b0;
                  if (b == C_STOP2) begin
                     do_st  = 1'b1;
                     st_val = C_XSTOP;
                  end
               end else if (b <= C_CTRL_MAX) begin
                  if (b == C_CR && r.tw) begin
                     n.top = inc_row(r.top);
                     n.col = '0;
                     n.clr = '0;
                     n.st  = ST_CLEAR;
                  end else if (b == C_XMARK_IN) begin
                     do_st  = 1'b1;
                     st_val = C_XMARK;
                  end else if (b == C_RJF_IN) begin
                     do_st  = 1'b1;
                     st_val = C_RJF;
                  end else if (b == C_KANA_IN) begin
                     do_st       = 1'b1;
                     st_val      = C_XSTOP;
                     n.kana_seen = 1'b1;
                  end else if (b == C_STOP1) begin
                     n.esc = 1'b1;
                  end
               end else if (b == C_SUPP_NULL) begin
                  do_st  = 1'b1;
                  st_val = C_SUPP_NULL;
               end else begin
                  do_st  = 1'b1;
                  st_val = xlate(b, r.fg);
               end
            end
         end
         ST_MARK: begin
            if (!r.trunc) begin
               do_st  = 1'b1;
               st_val = C_XMARK;
            end
            n.st   = ST_IDLE;
            n.done = 1'b1;
         end
      endcase
      if (do_st) begin
         n.dm_we   = 1'b1;
         n.dm_addr = phys(r.row, r.col, r.top);
         n.dm_data = st_val;
         if (r.col != COL_W'(SCR_COLS - 1)) begin
            n.col = r.col + 1'b1;
         end else if (r.st == ST_DATA && r.tw) begin
            n.trunc = 1'b1;
         end else begin
            n.col = '0;
            n.row = inc_row(r.row);
         end
      end
      n.idle = (n.st == ST_IDLE);
   end

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         r      <= '0;
         r.st   <= ST_IDLE;
         r.idle <= 1'b1;
      end else if (i_ce) begin
         r <= n;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign o_tx_valid       = r.tx_v;
   assign o_tx_byte        = r.tx_byte;
   assign o_odd_field      = r.odd;
   assign o_dm_we          = r.dm_we;
   assign o_dm_addr        = r.dm_addr;
   assign o_dm_data        = r.dm_data;
   assign o_top_row        = r.top;
   assign o_cursor_row     = r.row;
   assign o_cursor_col     = r.col;
   assign o_idle           = r.idle;
   assign o_kbd_ctrl_valid = r.kc_v;
   assign o_kbd_ctrl       = r.kc;
   assign o_write_done     = r.done;
   assign o_bcc_ok         = r.bcc_ok;
   assign o_kana_entry     = r.kbd_kana;

endmodule

`default_nettype wire

// ---- terminal_char_translation_test.sv ----
// Purpose : Self-checking bench for the translation unit.
// Assumes : Expected codes queued by the driver, popped by a monitor.
// Notes   : FIFO is filled while idle before the first write only; later writes get their data after start.
`timescale 1ns/1ns
`default_nettype none
module terminal_char_translation_test
   import tct_pkg::*;
;
   logic i_mclk, i_resetn, i_ce, i_host_last, i_host_valid, i_wr_start;
   logic i_typewriter, i_fg_mode, i_key_valid, i_tx_valid, i_tx_kana;
   logic i_frame_start, o_host_ready, o_tx_valid, o_odd_field, o_dm_we;
   logic o_idle, o_kbd_ctrl_valid, o_write_done, o_bcc_ok, o_kana_entry;
   logic [7:0]        i_host_data, i_tx_byte, o_tx_byte, o_dm_data;
   logic [7:0]        o_kbd_ctrl, b, bcc;
   logic [6:0]        i_key_pos;
   logic [ADDR_W-1:0] o_dm_addr;
   logic [ROW_W-1:0]  o_top_row, o_cursor_row;
   logic [COL_W-1:0]  o_cursor_col;
   logic [7:0]        q_dm[$], q_tx[$], q_ctl[$];
   logic              k, f;
   int                fail_count, n_checks, seed, t, a;
   logic [7:0] fx [14] = '{8'h0C, 8'h0B, 8'h0F, 8'h04, 8'h09, 8'h80,
      8'h82, 8'h83, 8'hC5, 8'hAA, 8'h41, 8'h90, 8'h0D, 8'h05};
   logic [7:0] ex [11] = '{8'h81, 8'h82, 8'h83, 8'h83, 8'h80, 8'h20,
      8'h20, 8'h65, 8'h0A, 8'h41, 8'h10};

   terminal_char_translation terminal_char_translation_inst (.i_mclk,
      .i_resetn, .i_ce, .i_host_data, .i_host_last, .i_host_valid,
      .o_host_ready, .i_wr_start, .i_typewriter, .i_fg_mode, .i_key_valid,
      .i_key_pos, .i_tx_valid, .i_tx_byte, .i_tx_kana, .o_tx_valid,
      .o_tx_byte, .i_frame_start, .o_odd_field, .o_dm_we, .o_dm_addr,
      .o_dm_data, .o_top_row, .o_cursor_row, .o_cursor_col, .o_idle,
      .o_kbd_ctrl_valid, .o_kbd_ctrl, .o_write_done, .o_bcc_ok,
      .o_kana_entry);
   dm_model dm_model_inst (.i_mclk, .i_we(o_dm_we), .i_addr(o_dm_addr),
      .i_data(o_dm_data));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   initial begin
      i_mclk = 1'b0;
      forever #10 i_mclk = ~i_mclk;
   end
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge i_mclk);
         #1;
      end
   endtask
   task automatic check(input string nm, input logic [7:0] e,
                        input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic take(ref logic [7:0] q[$], input string nm,
                       input logic [7:0] g);
      check(nm, (q.size() > 0) ? q.pop_front() : ~g, g);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   function automatic logic [7:0] dexp(input logic [7:0] d,
                                       input logic fg);
      logic [7:0] s;
      s = {1'b0, d[6:0]};
      if (s <= C_LOW_MAX) s = C_SPACE;
      if (d inside {[8'hA0:8'hDF]}) s = d - (d[6] ? 8'h60 : 8'hA0);
      return {fg, s[6:0]};
   endfunction
   function automatic logic [7:0] txe(input logic [7:0] d, input logic kn);
      logic [3:0] h;
      h = d[7:4];
      if (kn && d[6:4] inside {3'h0, 3'h1, 3'h6, 3'h7})
         h = 4'hA + {2'b00, d[6], d[4]};
      return {h, d[3:0]};
   endfunction
   task automatic send(input logic [7:0] d, input logic l);
      i_host_data = d;
      i_host_last = l;
      i_host_valid = 1'b1;
      while (o_host_ready !== 1'b1) tick(1);
      tick(1);
   endtask
   task automatic key(input logic [6:0] p);
      i_key_pos = p;
      i_key_valid = 1'b1;
      tick(1);
      i_key_valid = 1'b0;
      tick(1);
   endtask
   task automatic start(input logic tw, input logic fg);
      i_typewriter = tw;
      i_fg_mode = fg;
      i_wr_start = 1'b1;
      tick(1);
      i_wr_start = 1'b0;
   endtask
   task automatic wait_done();
      int n;
      n = 0;
      while (o_write_done !== 1'b1 && n < 5000) begin
         n++;
         tick(1);
      end
      check("write_done", 8'h00, 8'(n / 5000));
   endtask
   task automatic blanks();
      repeat (80) q_dm.push_back(C_SPACE);
   endtask
   always @(negedge i_mclk) begin
      if (i_resetn === 1'b1) begin
         if (o_dm_we === 1'b1) take(q_dm, "dm_data", o_dm_data);
         if (o_tx_valid === 1'b1) take(q_tx, "tx_byte", o_tx_byte);
         if (o_kbd_ctrl_valid === 1'b1) take(q_ctl, "kbd_ctrl", o_kbd_ctrl);
      end
   end
   initial begin
      #400_000;
      fail_count++;
      close_out();
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      seed = 32'hac4f_7eb5;
      {i_resetn, i_host_last, i_host_valid, i_wr_start, i_typewriter} = '0;
      {i_fg_mode, i_key_valid, i_tx_valid, i_tx_kana, i_frame_start} = '0;
      {i_host_data, i_tx_byte, i_key_pos} = '0;
      i_ce = 1'b1;
      repeat (20) @(posedge i_mclk);
      #1;
      i_resetn = 1'b1;
      check("idle", 8'h01, 8'(o_idle));
      check("host_ready", 8'h01, 8'(o_host_ready));
      check("kana_entry", 8'h00, 8'(o_kana_entry));
      q_dm.push_back(8'hC1);
      key(7'h21);
      key(KEY_KANA);
      check("kana_entry", 8'h01, 8'(o_kana_entry));
      q_dm.push_back(8'hE5);
      key(7'h45);
      key(KEY_LATIN);
      check("kana_entry", 8'h00, 8'(o_kana_entry));
      q_ctl.push_back(8'h0D);
      key(7'h6D);
      key(7'h7F);
      bcc = 8'h00;
      foreach (ex[i]) q_dm.push_back(ex[i]);
      for (int i = 0; i < 31; i++) begin
         b = (i < 14) ? fx[i] : 8'($random(seed));
         if (i >= 14 && (b < 8'h10 || b == 8'h80)) b = 8'h55;
         if (i >= 14) q_dm.push_back(dexp(b, 1'b0));
         bcc ^= b;
         send(b, 1'b0);
      end
      send(bcc, 1'b1);
      i_host_valid = 1'b0;
      tick(1);
      check("host_ready", 8'h00, 8'(o_host_ready));
      start(1'b0, 1'b0);
      wait_done();
      check("bcc_ok", 8'h01, 8'(o_bcc_ok));
      check("kana_entry", 8'h01, 8'(o_kana_entry));
      start(1'b0, 1'b1);
      q_dm.push_back(8'hC1);
      send(8'h41, 1'b0);
      send(8'h00, 1'b1);
      i_host_valid = 1'b0;
      wait_done();
      check("bcc_ok", 8'h00, 8'(o_bcc_ok));
      t = int'(o_top_row);
      blanks();
      start(1'b1, 1'b1);
      check("top_row", 8'((t + 1) % 24), 8'(o_top_row));
      check("cursor_row", 8'd23, 8'(o_cursor_row));
      q_dm.push_back(8'h41);
      q_dm.push_back(8'h42);
      send(8'h41, 1'b0);
      send(8'h42, 1'b0);
      blanks();
      send(C_CR, 1'b0);
      q_dm.push_back(8'h43);
      q_dm.push_back(C_XMARK);
      send(8'h43, 1'b0);
      send(8'h41 ^ 8'h42 ^ C_CR ^ 8'h43, 1'b1);
      i_host_valid = 1'b0;
      wait_done();
      check("top_row", 8'((t + 2) % 24), 8'(o_top_row));
      a = ((23 + int'(o_top_row)) % 24) * 80;
      check("bottom_line", 8'h43, dm_model_inst.mem[a]);
      blanks();
      start(1'b1, 1'b0);
      bcc = 8'h00;
      for (int i = 0; i < 82; i++) begin
         b = 8'h20 + 8'($random(seed) & 32'h3F);
         if (i < 80) q_dm.push_back(b);
         bcc ^= b;
         send(b, 1'b0);
      end
      send(bcc, 1'b1);
      i_host_valid = 1'b0;
      wait_done();
      f = o_odd_field;
      i_ce = 1'b0;
      i_frame_start = 1'b1;
      tick(2);
      check("odd_field", {7'h0, f}, 8'(o_odd_field));
      i_ce = 1'b1;
      tick(1);
      i_frame_start = 1'b0;
      tick(1);
      check("odd_field", {7'h0, ~f}, 8'(o_odd_field));
      i_tx_valid = 1'b1;
      for (int i = 0; i < 20; i++) begin
         b = (i == 0) ? 8'h65 : 8'($random(seed));
         k = (i == 0) ? 1'b1 : 1'($random(seed));
         i_tx_byte = b;
         i_tx_kana = k;
         q_tx.push_back(txe(b, k));
         tick(1);
      end
      i_tx_valid = 1'b0;
      tick(3);
      check("dm_left", 8'h00, 8'(q_dm.size()));
      check("tx_left", 8'h00, 8'(q_tx.size()));
      check("ctl_left", 8'h00, 8'(q_ctl.size()));
      close_out();
   end
endmodule
`default_nettype wire
